//--- ram_protect_defs.svh
`ifndef RAM_PROTECT_DEFS_SVH
`define RAM_PROTECT_DEFS_SVH
// Function
// - With protect_enable clear, every CPU and coprocessor RAM write is allowed.
// - With protect_enable set the write check runs and boundary registers ignore writes; clear, they accept writes.
// - With protection on, a coprocessor write outside its own region and the shared region is suppressed.
// - With protection on, a CPU write into the coprocessor RAM region sets violation_flag (bit 0).
// - Writing one to violation_flag clears it; writing zero leaves it alone.
// - The violation interrupt is high exactly while violation_irq_enable (bit 1) and violation_flag are set.
// - shared_region_upper_bound is written only while protect_enable is 0 and is readable at any time.
// - The 7-bit upper bound counts 256-byte blocks and the block it names belongs to the shared region.
// - The 8-bit program_page_index selects which of 256 pages appears in the program page window.
// - After reset program_page_index holds page FE, giving linear flash in the upper address space.
// - With rom_high_map_select at 0, fixed page FD appears at 4000-7FFF whatever the page index.
// - Fixed page FF always appears in the topmost 16K window whatever the page index.

`define OFS_PAGE_INDEX      12'h000
`define OFS_PROT_CTRL       12'h004
`define OFS_SHARED_UB       12'h008
`define OFS_COPRO_LOWER     12'h00c
`define OFS_SHARED_LOWER    12'h010
`define OFS_EVENT_STATUS    12'h014
`define OFS_EVENT_CLEAR     12'h018
`define OFS_EVENT_ENABLE    12'h01c

`define BIT_PROTECT_ENABLE  7
`define BIT_IRQ_ENABLE      1
`define BIT_FLAG            0
`define EVT_CPU_VIOLATION   0
`define EVT_COPRO_SUPPRESS  1

`define RST_PAGE_INDEX      8'hfe
`define RST_SHARED_UB       7'h7f
`define RST_COPRO_LOWER     7'h00
`define RST_SHARED_LOWER    7'h00
`define RST_EVENT_ENABLE    2'h0

`define FIXED_LOW_PAGE      8'hfd
`define FIXED_TOP_PAGE      8'hff
`define WIN_FIXED_LOW       2'h1
`define WIN_PAGED           2'h2
`define WIN_FIXED_TOP       2'h3
`endif

//--- ram_protect_pkg.sv
package ram_protect_pkg;
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_FIXED_LOW,
		SRC_PAGED,
		SRC_FIXED_TOP
	} map_src_type;
endpackage

//--- ram_protect.sv
`include "ram_protect_defs.svh"

module ram_protect
	import ram_protect_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CPU_WR_REQ,
	input  wire logic [14:0] CPU_WR_ADDR,
	output logic             CPU_WR_GRANT,
	output logic             CPU_WR_DENY,
	input  wire logic        COPRO_WR_REQ,
	input  wire logic [14:0] COPRO_WR_ADDR,
	output logic             COPRO_WR_GRANT,
	output logic             COPRO_WR_DENY,
	input  wire logic        ROM_HIGH_MAP_SELECT,
	input  wire logic        MAP_VALID,
	input  wire logic [15:0] MAP_ADDR,
	output logic             FLASH_HIT,
	output logic      [7:0]  FLASH_PAGE,
	output logic             VIOLATION_IRQ,
	output logic             IRQ
);

	logic [7:0]  program_page_index;
	logic        protect_enable;
	logic        violation_irq_enable;
	logic        violation_flag;
	logic [6:0]  shared_region_upper_bound;
	logic [6:0]  copro_lower;
	logic [6:0]  shared_lower;
	logic [1:0]  event_status;
	logic [1:0]  event_enable;

	logic [7:0]  next_program_page_index;
	logic        next_protect_enable;
	logic        next_violation_irq_enable;
	logic        next_violation_flag;
	logic [6:0]  next_shared_region_upper_bound;
	logic [6:0]  next_copro_lower;
	logic [6:0]  next_shared_lower;
	logic [1:0]  next_event_status;
	logic [1:0]  next_event_enable;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_violation_irq;
	logic        next_irq;

	logic        setup;
	logic        wr_done;
	logic        mapped;
	logic        cpu_in_copro;
	logic        copro_in_copro;
	logic        copro_in_shared;
	logic        cpu_block;
	logic        copro_block;
	logic        bounds_open;

	logic        rom_map_meta;
	logic        rom_map_sync;
	map_src_type map_src;
	logic        next_flash_hit;
	logic [7:0]  next_flash_page;

	function automatic logic in_copro_region(input logic [14:0] addr, input logic [6:0] lo,
		input logic [6:0] sh_lo);
		in_copro_region = (addr[14:8] >= lo) && (addr[14:8] < sh_lo);
	endfunction

	// The named block itself is inside the shared region, hence the inclusive compare.
	function automatic logic in_shared_region(input logic [14:0] addr, input logic [6:0] sh_lo,
		input logic [6:0] sh_hi);
		in_shared_region = (addr[14:8] >= sh_lo) && (addr[14:8] <= sh_hi);
	endfunction

	assign cpu_in_copro = in_copro_region(CPU_WR_ADDR, copro_lower, shared_lower);
	assign copro_in_copro = in_copro_region(COPRO_WR_ADDR, copro_lower, shared_lower);
	assign copro_in_shared = in_shared_region(COPRO_WR_ADDR, shared_lower, shared_region_upper_bound);

	// Nothing is blocked while protection is off.
	assign cpu_block = protect_enable && CPU_WR_REQ && cpu_in_copro;
	assign copro_block = protect_enable && COPRO_WR_REQ && !copro_in_copro && !copro_in_shared;
	assign bounds_open = !protect_enable;

	// Read data and the answer are prepared in the setup cycle so every bus output is a flop.
	assign setup = PSEL && !PENABLE;
	assign wr_done = PSEL && PENABLE && PREADY && PWRITE;

	always_comb begin
		case (PADDR)
			`OFS_PAGE_INDEX, `OFS_PROT_CTRL, `OFS_SHARED_UB, `OFS_COPRO_LOWER,
			`OFS_SHARED_LOWER, `OFS_EVENT_STATUS, `OFS_EVENT_CLEAR, `OFS_EVENT_ENABLE: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_prdata = PRDATA;
		next_pready = setup;
		next_pslverr = setup && !mapped;
		if (setup && !PWRITE) begin
			next_prdata = 32'h0000_0000;
			case (PADDR)
				`OFS_PAGE_INDEX: begin
					next_prdata[7:0] = program_page_index;
				end
				`OFS_PROT_CTRL: begin
					next_prdata[`BIT_PROTECT_ENABLE] = protect_enable;
					next_prdata[`BIT_IRQ_ENABLE] = violation_irq_enable;
					next_prdata[`BIT_FLAG] = violation_flag;
				end
				`OFS_SHARED_UB: begin
					next_prdata[6:0] = shared_region_upper_bound;
				end
				`OFS_COPRO_LOWER: begin
					next_prdata[6:0] = copro_lower;
				end
				`OFS_SHARED_LOWER: begin
					next_prdata[6:0] = shared_lower;
				end
				`OFS_EVENT_STATUS: begin
					next_prdata[1:0] = event_status;
				end
				`OFS_EVENT_ENABLE: begin
					next_prdata[1:0] = event_enable;
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_comb begin
		next_program_page_index = program_page_index;
		next_protect_enable = protect_enable;
		next_violation_irq_enable = violation_irq_enable;
		next_violation_flag = violation_flag;
		next_shared_region_upper_bound = shared_region_upper_bound;
		next_copro_lower = copro_lower;
		next_shared_lower = shared_lower;
		next_event_status = event_status;
		next_event_enable = event_enable;
		if (wr_done) begin
			case (PADDR)
				`OFS_PAGE_INDEX: begin
					next_program_page_index = PWDATA[7:0];
				end
				`OFS_PROT_CTRL: begin
					next_protect_enable = PWDATA[`BIT_PROTECT_ENABLE];
					next_violation_irq_enable = PWDATA[`BIT_IRQ_ENABLE];
					next_violation_flag = violation_flag && !PWDATA[`BIT_FLAG];
				end
				`OFS_SHARED_UB: begin
					if (bounds_open) begin
						next_shared_region_upper_bound = PWDATA[6:0];
					end
				end
				`OFS_COPRO_LOWER: begin
					if (bounds_open) begin
						next_copro_lower = PWDATA[6:0];
					end
				end
				`OFS_SHARED_LOWER: begin
					if (bounds_open) begin
						next_shared_lower = PWDATA[6:0];
					end
				end
				`OFS_EVENT_CLEAR: begin
					next_event_status = event_status & ~PWDATA[1:0];
				end
				`OFS_EVENT_ENABLE: begin
					next_event_enable = PWDATA[1:0];
				end
				default: begin
					next_event_enable = event_enable;
				end
			endcase
		end
		// A violation in the same cycle as its clear must not be lost, so the set comes last.
		if (cpu_block) begin
			next_violation_flag = 1'b1;
			next_event_status[`EVT_CPU_VIOLATION] = 1'b1;
		end
		if (copro_block) begin
			next_event_status[`EVT_COPRO_SUPPRESS] = 1'b1;
		end
		next_violation_irq = next_violation_flag && next_violation_irq_enable;
		next_irq = |(next_event_status & next_event_enable);
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			program_page_index <= `RST_PAGE_INDEX;
			protect_enable <= 1'b0;
			violation_irq_enable <= 1'b0;
			violation_flag <= 1'b0;
			shared_region_upper_bound <= `RST_SHARED_UB;
			copro_lower <= `RST_COPRO_LOWER;
			shared_lower <= `RST_SHARED_LOWER;
			event_status <= 2'h0;
			event_enable <= `RST_EVENT_ENABLE;
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			VIOLATION_IRQ <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			program_page_index <= next_program_page_index;
			protect_enable <= next_protect_enable;
			violation_irq_enable <= next_violation_irq_enable;
			violation_flag <= next_violation_flag;
			shared_region_upper_bound <= next_shared_region_upper_bound;
			copro_lower <= next_copro_lower;
			shared_lower <= next_shared_lower;
			event_status <= next_event_status;
			event_enable <= next_event_enable;
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
			VIOLATION_IRQ <= next_violation_irq;
			IRQ <= next_irq;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			CPU_WR_GRANT <= 1'b0;
			CPU_WR_DENY <= 1'b0;
			COPRO_WR_GRANT <= 1'b0;
			COPRO_WR_DENY <= 1'b0;
		end else begin
			CPU_WR_GRANT <= CPU_WR_REQ && !cpu_block;
			CPU_WR_DENY <= cpu_block;
			COPRO_WR_GRANT <= COPRO_WR_REQ && !copro_block;
			COPRO_WR_DENY <= copro_block;
		end
	end

	always_comb begin
		case (MAP_ADDR[15:14])
			`WIN_FIXED_TOP: begin
				map_src = SRC_FIXED_TOP;
			end
			`WIN_PAGED: begin
				map_src = SRC_PAGED;
			end
			`WIN_FIXED_LOW: begin
				map_src = rom_map_sync ? SRC_NONE : SRC_FIXED_LOW;
			end
			default: begin
				map_src = SRC_NONE;
			end
		endcase
	end

	always_comb begin
		next_flash_hit = MAP_VALID;
		case (map_src)
			SRC_FIXED_TOP: begin
				next_flash_page = `FIXED_TOP_PAGE;
			end
			SRC_PAGED: begin
				next_flash_page = program_page_index;
			end
			SRC_FIXED_LOW: begin
				next_flash_page = `FIXED_LOW_PAGE;
			end
			default: begin
				next_flash_hit = 1'b0;
				next_flash_page = 8'h00;
			end
		endcase
	end

	// The map option is a pin, so it is synchronised before the decode reads it.
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			rom_map_meta <= 1'b0;
			rom_map_sync <= 1'b0;
			FLASH_HIT <= 1'b0;
			FLASH_PAGE <= 8'h00;
		end else begin
			rom_map_meta <= ROM_HIGH_MAP_SELECT;
			rom_map_sync <= rom_map_meta;
			FLASH_HIT <= next_flash_hit;
			FLASH_PAGE <= next_flash_page;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	sequence s_ctrl_write;
		wr_done && PADDR == `OFS_PROT_CTRL;
	endsequence

	sequence s_flag_clear;
		s_ctrl_write ##0 PWDATA[`BIT_FLAG] && !cpu_block;
	endsequence

	logic past_reset;
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			past_reset <= 1'b1;
		end else begin
			past_reset <= 1'b0;
		end
	end

	a_open_cpu_write: assert property (CPU_WR_REQ && !protect_enable |=> CPU_WR_GRANT && !CPU_WR_DENY)
		else $error("CPU write refused while protection is off");
	a_locked_bounds: assert property (wr_done && protect_enable && PADDR == `OFS_COPRO_LOWER |=>
		$stable(copro_lower))
		else $error("Boundary register changed while protection is on");
	a_copro_outside: assert property (protect_enable && COPRO_WR_REQ && !copro_in_copro && !copro_in_shared
		|=> COPRO_WR_DENY && !COPRO_WR_GRANT)
		else $error("Stray coprocessor write was not suppressed");
	a_cpu_violation: assert property (protect_enable && CPU_WR_REQ && cpu_in_copro |=> violation_flag)
		else $error("CPU write into coprocessor region did not set the flag");
	a_flag_clear: assert property (s_flag_clear |=> !violation_flag)
		else $error("Writing one did not clear the flag");
	a_flag_keep: assert property (s_ctrl_write ##0 !PWDATA[`BIT_FLAG] && violation_flag |=> violation_flag)
		else $error("Writing zero cleared the flag");
	a_violation_irq: assert property (VIOLATION_IRQ == (violation_flag && violation_irq_enable))
		else $error("Violation interrupt does not follow flag and enable");
	a_bound_open: assert property (wr_done && !protect_enable && PADDR == `OFS_SHARED_UB |=>
		shared_region_upper_bound == $past(PWDATA[6:0]))
		else $error("Upper bound write lost while protection is off");
	a_shared_top: assert property (protect_enable && COPRO_WR_REQ && COPRO_WR_ADDR[14:8] == shared_region_upper_bound
		&& shared_lower <= shared_region_upper_bound |=> COPRO_WR_GRANT)
		else $error("Top shared block refused to coprocessor");
	a_paged_window: assert property (MAP_VALID && MAP_ADDR[15:14] == `WIN_PAGED |=>
		FLASH_HIT && FLASH_PAGE == $past(program_page_index))
		else $error("Paged window does not show the page index");
	a_reset_page: assert property (past_reset |-> program_page_index == `RST_PAGE_INDEX)
		else $error("Page index not FE after reset");
	a_fixed_low: assert property (MAP_VALID && MAP_ADDR[15:14] == `WIN_FIXED_LOW && !rom_map_sync |=>
		FLASH_HIT && FLASH_PAGE == `FIXED_LOW_PAGE)
		else $error("Low fixed window does not show page FD");
	a_fixed_top: assert property (MAP_VALID && MAP_ADDR[15:14] == `WIN_FIXED_TOP |=>
		FLASH_PAGE == `FIXED_TOP_PAGE)
		else $error("Top window does not show page FF");
	a_flag_needs_prot: assert property ($rose(violation_flag) |-> $past(protect_enable))
		else $error("Flag set while protection was off");

endmodule

//--- ram_writer_model.sv
module ram_writer_model (
	input  wire logic        ref_clk,
	output logic             cpu_wr_req,
	output logic      [14:0] cpu_wr_addr,
	input  wire logic        cpu_wr_grant,
	input  wire logic        cpu_wr_deny,
	output logic             copro_wr_req,
	output logic      [14:0] copro_wr_addr,
	input  wire logic        copro_wr_grant,
	input  wire logic        copro_wr_deny
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cpu_wr_req = 1'b0;
		copro_wr_req = 1'b0;
		cpu_wr_addr = 15'h0000;
		copro_wr_addr = 15'h0000;
	end

	// A released address shows its inverse, so a design that latches it late sees garbage.
	task automatic write_ram(input logic copro, input logic [14:0] addr, output logic [1:0] answer);
		@(posedge ref_clk);
		if (copro) begin
			copro_wr_req <= 1'b1;
			copro_wr_addr <= addr;
		end else begin
			cpu_wr_req <= 1'b1;
			cpu_wr_addr <= addr;
		end
		@(posedge ref_clk);
		cpu_wr_req <= 1'b0;
		copro_wr_req <= 1'b0;
		cpu_wr_addr <= ~addr;
		copro_wr_addr <= ~addr;
		// The answer is registered at the edge that takes the request, so it is read at the following edge.
		@(posedge ref_clk);
		answer = copro ? {copro_wr_grant, copro_wr_deny} : {cpu_wr_grant, cpu_wr_deny};
	endtask
endmodule

//--- test_ram_protect.sv
module test_ram_protect;
	timeunit 1ns;
	timeprecision 1ns;

	logic        REF_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic        CPU_WR_REQ, CPU_WR_GRANT, CPU_WR_DENY, COPRO_WR_REQ, COPRO_WR_GRANT, COPRO_WR_DENY;
	logic [14:0] CPU_WR_ADDR, COPRO_WR_ADDR;
	logic        ROM_HIGH_MAP_SELECT, MAP_VALID, FLASH_HIT, VIOLATION_IRQ, IRQ;
	logic [15:0] MAP_ADDR;
	logic [7:0]  FLASH_PAGE;
	int          mismatches = 0;
	int          checks = 0;
	logic [31:0] rd;
	logic        err;

	ram_protect dut (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CPU_WR_REQ(CPU_WR_REQ), .CPU_WR_ADDR(CPU_WR_ADDR), .CPU_WR_GRANT(CPU_WR_GRANT),
		.CPU_WR_DENY(CPU_WR_DENY), .COPRO_WR_REQ(COPRO_WR_REQ), .COPRO_WR_ADDR(COPRO_WR_ADDR),
		.COPRO_WR_GRANT(COPRO_WR_GRANT), .COPRO_WR_DENY(COPRO_WR_DENY),
		.ROM_HIGH_MAP_SELECT(ROM_HIGH_MAP_SELECT), .MAP_VALID(MAP_VALID), .MAP_ADDR(MAP_ADDR),
		.FLASH_HIT(FLASH_HIT), .FLASH_PAGE(FLASH_PAGE), .VIOLATION_IRQ(VIOLATION_IRQ), .IRQ(IRQ));

	ram_writer_model writer (.ref_clk(REF_CLK), .cpu_wr_req(CPU_WR_REQ), .cpu_wr_addr(CPU_WR_ADDR),
		.cpu_wr_grant(CPU_WR_GRANT), .cpu_wr_deny(CPU_WR_DENY), .copro_wr_req(COPRO_WR_REQ),
		.copro_wr_addr(COPRO_WR_ADDR), .copro_wr_grant(COPRO_WR_GRANT), .copro_wr_deny(COPRO_WR_DENY));

	always #25 REF_CLK = ~REF_CLK;

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// PREADY, PRDATA and PSLVERR are read right at the rising edge, before that edge updates them.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge REF_CLK);
			if (PREADY === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			final_report();
		end
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// One more edge lets the registers and interrupt outputs settle before anything is compared.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
		@(posedge REF_CLK);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check(rd, exp);
	endtask

	task automatic ram(input logic copro, input logic [14:0] a, input logic [1:0] exp);
		logic [1:0] ans;
		writer.write_ram(copro, a, ans);
		check({30'h0000_0000, ans}, {30'h0000_0000, exp});
	endtask

	task automatic map_chk(input logic [15:0] a, input logic hit, input logic [7:0] page);
		@(posedge REF_CLK);
		MAP_VALID <= 1'b1;
		MAP_ADDR <= a;
		@(posedge REF_CLK);
		MAP_VALID <= 1'b0;
		@(posedge REF_CLK);
		check({23'h00_0000, FLASH_HIT, FLASH_PAGE}, {23'h00_0000, hit, page});
	endtask

	initial begin
		REF_CLK = 1'b0;
		RESET = 1'b1;
		{PSEL, PENABLE, PWRITE, MAP_VALID, ROM_HIGH_MAP_SELECT} = 5'h00;
		PADDR = 12'h000;
		PWDATA = 32'h0000_0000;
		MAP_ADDR = 16'h0000;
		repeat (16) @(posedge REF_CLK);
		RESET <= 1'b0;
		rd_chk(12'h000, 32'h0000_00fe);
		rd_chk(12'h004, 32'h0000_0000);
		rd_chk(12'h008, 32'h0000_007f);
		apb(1'b0, 12'h020, 32'h0000_0000, rd, err);
		check({rd[30:0], err}, 32'h0000_0001);
		$display("test reset values done");
		ram(1'b0, 15'h0500, 2'b10);
		ram(1'b1, 15'h7f00, 2'b10);
		rd_chk(12'h004, 32'h0000_0000);
		wr(12'h010, 32'h0000_0010);
		wr(12'h008, 32'h0000_0020);
		rd_chk(12'h008, 32'h0000_0020);
		$display("test protection off done");
		wr(12'h004, 32'h0000_0080);
		wr(12'h008, 32'h0000_0030);
		rd_chk(12'h008, 32'h0000_0020);
		wr(12'h010, 32'h0000_0018);
		rd_chk(12'h010, 32'h0000_0010);
		wr(12'h00c, 32'h0000_0005);
		rd_chk(12'h00c, 32'h0000_0000);
		ram(1'b1, 15'h0f00, 2'b10);
		ram(1'b1, 15'h20ff, 2'b10);
		ram(1'b1, 15'h2100, 2'b01);
		ram(1'b0, 15'h1500, 2'b10);
		ram(1'b0, 15'h0500, 2'b01);
		rd_chk(12'h004, 32'h0000_0081);
		check({31'h0000_0000, VIOLATION_IRQ}, 32'h0000_0000);
		wr(12'h004, 32'h0000_0082);
		check({31'h0000_0000, VIOLATION_IRQ}, 32'h0000_0001);
		rd_chk(12'h004, 32'h0000_0083);
		wr(12'h004, 32'h0000_0083);
		check({31'h0000_0000, VIOLATION_IRQ}, 32'h0000_0000);
		rd_chk(12'h004, 32'h0000_0082);
		$display("test protection on done");
		rd_chk(12'h014, 32'h0000_0003);
		check({31'h0000_0000, IRQ}, 32'h0000_0000);
		wr(12'h01c, 32'h0000_0001);
		check({31'h0000_0000, IRQ}, 32'h0000_0001);
		wr(12'h018, 32'h0000_0001);
		check({31'h0000_0000, IRQ}, 32'h0000_0000);
		rd_chk(12'h014, 32'h0000_0002);
		wr(12'h01c, 32'h0000_0002);
		check({31'h0000_0000, IRQ}, 32'h0000_0001);
		wr(12'h018, 32'h0000_0002);
		check({31'h0000_0000, IRQ}, 32'h0000_0000);
		$display("test events done");
		map_chk(16'hc123, 1'b1, 8'hff);
		map_chk(16'h8000, 1'b1, 8'hfe);
		map_chk(16'h4000, 1'b1, 8'hfd);
		map_chk(16'h0100, 1'b0, 8'h00);
		wr(12'h000, 32'h0000_0037);
		map_chk(16'hbfff, 1'b1, 8'h37);
		map_chk(16'hffff, 1'b1, 8'hff);
		@(posedge REF_CLK);
		ROM_HIGH_MAP_SELECT <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		map_chk(16'h4000, 1'b0, 8'h00);
		$display("test flash map done");
		final_report();
	end
endmodule
